// ===== dio_port_pkg.sv
// Shared constants and carrier types for the 96-line static digital I/O block
package dio_port_pkg;
   localparam int PORT_COUNT = 12;
   localparam int LINE_COUNT = 8;
   localparam int LINE_TOTAL = PORT_COUNT * LINE_COUNT;
   localparam int PORT_SEL_WIDTH = 4;
   // Power-up state codes per line
   localparam logic [1:0] PUP_HIGHZ = 2'h0;
   localparam logic [1:0] PUP_HIGH = 2'h1;
   localparam logic [1:0] PUP_LOW = 2'h2;
   localparam logic [7:0] PORT_ZERO = 8'h00;
   localparam logic [LINE_TOTAL-1:0] LINES_ZERO = '0;
   localparam logic [PORT_COUNT-1:0] DIR_ALL_INPUT = '0;

   typedef enum logic [1:0] {
      ACC_NONE,
      ACC_WRITE_DATA,
      ACC_WRITE_DIR,
      ACC_READ
   } access_kind_t;

   // One software-timed static access
   typedef struct packed {
      access_kind_t kind;
      logic [PORT_SEL_WIDTH-1:0] port;
      logic [7:0] data;
      logic dirOut;
   } sw_access_t;

   // Pin driver group, output enable low while driving
   typedef struct packed {
      logic [LINE_TOTAL-1:0] level;
      logic [LINE_TOTAL-1:0] oeN;
   } pin_drive_t;
endpackage : dio_port_pkg

// ===== ext_loads.sv
// Outside loads and signal sources facing the 96 lines
`timescale 1ns/1ps
module ext_loads (
   input wire logic core_clk,
   input wire dio_port_pkg::pin_drive_t pinDrive,
   input wire logic [dio_port_pkg::LINE_TOTAL-1:0] pullLevel,
   input wire logic pullEnable,
   input wire logic [dio_port_pkg::LINE_TOTAL-1:0] srcLevel,
   input wire logic [dio_port_pkg::LINE_TOTAL-1:0] srcEn,
   output logic [dio_port_pkg::LINE_TOTAL-1:0] pinIn
);
   import dio_port_pkg::*;
   logic floatBit = 1'b0;
   // Unpulled lines wander, so a stale value never passes
   always @(posedge core_clk) floatBit <= ~floatBit;
   // Sources touch only lines the block has released
   always_comb begin
      for (int i = 0; i < LINE_TOTAL; i++) begin
         if (!pinDrive.oeN[i]) pinIn[i] = pinDrive.level[i];
         else if (srcEn[i]) pinIn[i] = srcLevel[i];
         else if (pullEnable) pinIn[i] = pullLevel[i];
         else pinIn[i] = floatBit;
      end
   end
endmodule : ext_loads

// ===== static_dio_port.sv
// Static 96-line digital I/O block with per-port direction and power-up states
`timescale 1ns/1ps
// Operation
// RULE1: There are 96 two-way lines as twelve ports of eight lines each.
// RULE2: In a port value, line 7 is the top bit and line 0 the bottom bit.
// RULE3: Direction is chosen per port, so all eight lines share it.
// RULE4: Sampling and updating happen only on a software access, one at a time.
// RULE5: After power-on every line is an input unless a power-up state says otherwise.
// RULE6: One global pull select weakly pulls all lines high or low.
// RULE7: The weak pull is present on every line whatever its direction.
// RULE8: Each line may have its own power-up state: high impedance, high or low.
// RULE9: When powered off or suspended, all lines are unpowered.
// RULE10: Outside circuits must not drive, ground or supply a line set as output.
// RULE11: Output ports drive their last written value; input ports release and are read.
// RULE12: Power-up states sit in retained storage and apply before software access.
module static_dio_port #(
   parameter int PORTS = 12,
   parameter int LINES = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic powerOn,
   input wire logic suspend,
   input wire logic pullSelHigh,
   input wire logic [dio_port_pkg::LINE_TOTAL*2-1:0] powerUpState,
   input wire dio_port_pkg::sw_access_t swAccess,
   output logic accessReady,
   output logic [7:0] readData,
   output logic readValid,
   output logic [dio_port_pkg::PORT_COUNT-1:0] portDirOut,
   input wire logic [dio_port_pkg::LINE_TOTAL-1:0] pinIn,
   output dio_port_pkg::pin_drive_t pinDrive,
   output logic [dio_port_pkg::LINE_TOTAL-1:0] pullLevel,
   output logic pullEnable
);
   import dio_port_pkg::*;

   // Refuse sizes the fixed pin map cannot serve
   if (PORTS != PORT_COUNT || LINES != LINE_COUNT) begin : g_size_check
      $error("static_dio_port supports only 12 ports of 8 lines");
   end

   typedef enum {ST_OFF, ST_APPLY, ST_RUN} pwr_state_t;

   pwr_state_t state;
   pwr_state_t next_state;
   logic [LINE_TOTAL-1:0] outLatch;
   logic [LINE_TOTAL-1:0] next_outLatch;
   logic [LINE_TOTAL-1:0] lineOut;
   logic [LINE_TOTAL-1:0] next_lineOut;
   logic [LINE_TOTAL-1:0] pinSync1;
   logic [LINE_TOTAL-1:0] pinSync2;
   logic pwrSync1;
   logic pwrSync2;
   logic suspSync1;
   logic suspSync2;
   logic [7:0] next_readData;
   logic next_readValid;
   logic powered;

   // Pins and power inputs come from outside the clock domain
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinSync1 <= LINES_ZERO;
         pinSync2 <= LINES_ZERO;
         pwrSync1 <= 1'b0;
         pwrSync2 <= 1'b0;
         suspSync1 <= 1'b0;
         suspSync2 <= 1'b0;
      end else begin
         pinSync1 <= pinIn;
         pinSync2 <= pinSync1;
         pwrSync1 <= powerOn;
         pwrSync2 <= pwrSync1;
         suspSync1 <= suspend;
         suspSync2 <= suspSync1;
      end
   end

   assign powered = pwrSync2 && !suspSync2;

   // Power sequencing and static access handling
   always_comb begin
      next_state = state;
      next_outLatch = outLatch;
      next_lineOut = lineOut;
      next_readData = readData;
      next_readValid = 1'b0;
      case (state)
         ST_OFF: begin
            next_lineOut = LINES_ZERO; // All inputs on power-on [RULE5]
            if (powered) begin
               next_state = ST_APPLY;
            end
         end
         ST_APPLY: begin
            // Retained power-up states applied before access opens [RULE8] [RULE12]
            for (int i = 0; i < LINE_TOTAL; i++) begin
               next_lineOut[i] = (powerUpState[2*i +: 2] == PUP_HIGH) ||
                                 (powerUpState[2*i +: 2] == PUP_LOW);
               next_outLatch[i] = (powerUpState[2*i +: 2] == PUP_HIGH);
            end
            // Power lost mid-apply must not leave lines driven [RULE9]
            if (!powered) begin
               next_lineOut = LINES_ZERO;
            end
            next_state = powered ? ST_RUN : ST_OFF;
         end
         ST_RUN: begin
            if (!powered) begin
               next_state = ST_OFF; // Lines go dead off or suspended [RULE9]
               next_lineOut = LINES_ZERO;
            end else begin
               // One software access per cycle, nothing hardware timed [RULE4]
               case (swAccess.kind)
                  ACC_WRITE_DATA: begin
                     next_outLatch[swAccess.port*LINE_COUNT +: LINE_COUNT] =
                        swAccess.data; // Bit 7 maps to line 7 [RULE2]
                  end
                  ACC_WRITE_DIR: begin
                     // Whole port switches together [RULE3]
                     next_lineOut[swAccess.port*LINE_COUNT +: LINE_COUNT] =
                        {LINE_COUNT{swAccess.dirOut}};
                  end
                  ACC_READ: begin
                     // Output ports read back their latch, inputs the pins [RULE11]
                     for (int b = 0; b < LINE_COUNT; b++) begin
                        next_readData[b] = lineOut[swAccess.port*LINE_COUNT + b] ?
                           outLatch[swAccess.port*LINE_COUNT + b] :
                           pinSync2[swAccess.port*LINE_COUNT + b];
                     end
                     next_readValid = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         default: next_state = ST_OFF;
      endcase
      // Out-of-range port numbers are ignored
      if (swAccess.port >= PORT_SEL_WIDTH'(PORT_COUNT)) begin
         next_outLatch = (state == ST_RUN) ? outLatch : next_outLatch;
         next_lineOut = (state == ST_RUN && powered) ? lineOut : next_lineOut;
         next_readData = readData; // Keeps the last answer, never an unknown
         next_readValid = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_OFF;
         outLatch <= LINES_ZERO;
         lineOut <= LINES_ZERO;
         readData <= PORT_ZERO;
         readValid <= 1'b0;
      end else begin
         state <= next_state;
         outLatch <= next_outLatch;
         lineOut <= next_lineOut;
         readData <= next_readData;
         readValid <= next_readValid;
      end
   end

   // Ready only while running, so power-up states always win [RULE12]
   assign accessReady = (state == ST_RUN) && powered;

   // Per-port direction view, taken from line 0 of each port [RULE3]
   always_comb begin
      for (int p = 0; p < PORT_COUNT; p++) begin
         portDirOut[p] = lineOut[p*LINE_COUNT];
      end
   end

   // Pin drivers; outside parties must leave output lines alone [RULE10] [RULE11] [RULE1]
   assign pinDrive.level = outLatch & lineOut;
   assign pinDrive.oeN = ~lineOut;

   // Weak pull on every line regardless of direction, off when unpowered [RULE6] [RULE7]
   assign pullLevel = {LINE_TOTAL{pullSelHigh}};
   assign pullEnable = (state != ST_OFF);

   // Assertions
   sequence s_dirWrite;
      accessReady && swAccess.kind == ACC_WRITE_DIR && swAccess.port < PORT_SEL_WIDTH'(PORT_COUNT);
   endsequence

   port_uniform_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
      s_dirWrite |=> portDirOut[$past(swAccess.port)] == $past(swAccess.dirOut))
      else $error("Direction write did not reach the port");
   off_inputs_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE9]
      state == ST_OFF |-> pinDrive.oeN == ~LINES_ZERO)
      else $error("Line driven while unpowered");
   reset_input_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
      $rose(powered) && state == ST_OFF |=> lineOut == LINES_ZERO)
      else $error("Lines not inputs at power-on");
   apply_first_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE12]
      $rose(accessReady) |-> $past(state) == ST_APPLY)
      else $error("Access open before power-up states applied");
   pull_every_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
      pullEnable |-> pullLevel == {LINE_TOTAL{pullSelHigh}})
      else $error("Pull level differs on some line");
   pull_select_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
      pullSelHigh |-> pullLevel[0] && pullLevel[LINE_TOTAL-1])
      else $error("Pull select high not applied");
   read_answer_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
      accessReady && swAccess.kind == ACC_READ && swAccess.port < PORT_SEL_WIDTH'(PORT_COUNT)
      |=> readValid)
      else $error("Read gave no answer next cycle");
   bad_port_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
      accessReady && swAccess.kind == ACC_WRITE_DIR
         && swAccess.port >= PORT_SEL_WIDTH'(PORT_COUNT)
      |=> $stable(lineOut))
      else $error("Write to a missing port changed a direction");
   bad_read_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
      accessReady && swAccess.kind == ACC_READ
         && swAccess.port >= PORT_SEL_WIDTH'(PORT_COUNT)
      |=> !readValid && $stable(readData))
      else $error("Read of a missing port gave an answer");
   drive_value_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE11]
      accessReady && swAccess.kind == ACC_WRITE_DATA
         && swAccess.port == PORT_SEL_WIDTH'(PORT_COUNT - 1)
      ##1 accessReady && swAccess.kind == ACC_NONE && (&lineOut[LINE_TOTAL-1 -: LINE_COUNT])
      |-> pinDrive.level[LINE_TOTAL-1 -: LINE_COUNT] == $past(swAccess.data))
      else $error("Output port not driving its written value");
   pup_high_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
      state == ST_APPLY && powered && powerUpState[1:0] == PUP_HIGH
      |=> !pinDrive.oeN[0] && pinDrive.level[0])
      else $error("Power-up high not applied");
endmodule : static_dio_port

// ===== tb_static_dio_port.sv
// Self-checking bench for the static 96-line digital I/O block
`timescale 1ns/1ps
module tb_static_dio_port;
   import dio_port_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic powerOn = 1'b0;
   logic suspend = 1'b0;
   logic pullSelHigh = 1'b1;
   logic [LINE_TOTAL*2-1:0] powerUpState = '0;
   sw_access_t swAccess = '0;
   logic accessReady;
   logic readValid;
   logic pullEnable;
   logic [7:0] readData;
   logic [PORT_COUNT-1:0] portDirOut;
   logic [LINE_TOTAL-1:0] pinIn;
   logic [LINE_TOTAL-1:0] pullLevel;
   logic [LINE_TOTAL-1:0] srcLevel = '0;
   logic [LINE_TOTAL-1:0] srcEn = '0;
   pin_drive_t pinDrive;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;

   static_dio_port uut (.core_clk(core_clk), .sys_rst(sys_rst), .powerOn(powerOn),
      .suspend(suspend), .pullSelHigh(pullSelHigh), .powerUpState(powerUpState),
      .swAccess(swAccess), .accessReady(accessReady), .readData(readData),
      .readValid(readValid), .portDirOut(portDirOut), .pinIn(pinIn),
      .pinDrive(pinDrive), .pullLevel(pullLevel), .pullEnable(pullEnable));
   ext_loads far_side (.core_clk(core_clk), .pinDrive(pinDrive), .pullLevel(pullLevel),
      .pullEnable(pullEnable), .srcLevel(srcLevel), .srcEn(srcEn), .pinIn(pinIn));

   always #20 core_clk = ~core_clk;

   task automatic chk(input logic [LINE_TOTAL-1:0] seen, input logic [LINE_TOTAL-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One access held across a single sampling edge
   task automatic access(input access_kind_t k, input logic [3:0] p, input logic [7:0] d,
      input logic dir);
      @(negedge core_clk);
      swAccess = '{k, p, d, dir};
      @(negedge core_clk);
      swAccess.kind = ACC_NONE;
   endtask : access

   // Bounded wait, the answer pulse lasts one cycle
   task automatic read_port(input logic [3:0] p, input logic [7:0] exp);
      access(ACC_READ, p, 8'h00, 1'b0);
      for (int i = 0; i < 3 && readValid !== 1'b1; i++) @(negedge core_clk);
      chk(readValid, 1'b1);
      chk(readData, exp);
   endtask : read_port

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // Hang guard well above the roughly 60 cycles needed
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial begin
      powerUpState[1:0] = PUP_HIGH;
      powerUpState[3:2] = PUP_LOW;
      repeat (20) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      chk(pinDrive.oeN, '1);
      chk(accessReady, 1'b0);
      powerOn = 1'b1;
      repeat (8) @(negedge core_clk);
      chk(accessReady, 1'b1);
      chk(pinDrive.oeN, {{94{1'b1}}, 2'h0});
      chk(pinDrive.level[1:0], 2'h1);
      chk(pullLevel, '1);
      chk(pullEnable, 1'b1);
      // Port 11 to output, then a value with distinct upper and lower nibbles
      access(ACC_WRITE_DIR, 4'hB, 8'h00, 1'b1);
      access(ACC_WRITE_DATA, 4'hB, 8'hA5, 1'b0);
      @(negedge core_clk);
      chk(pinDrive.oeN[95:88], 8'h00);
      chk(pinDrive.level[95:88], 8'hA5);
      chk(pinDrive.oeN[87:8], {80{1'b1}});
      pullSelHigh = 1'b0;
      @(negedge core_clk);
      chk(pullLevel, '0);
      // Nonexistent port 12 must change nothing
      access(ACC_WRITE_DIR, 4'hC, 8'h00, 1'b1);
      @(negedge core_clk);
      chk(portDirOut[11:1], 11'h400);
      srcEn[23:16] = 8'hFF;
      srcLevel[23:16] = 8'h3C;
      repeat (3) @(negedge core_clk);
      read_port(4'h2, 8'h3C);
      repeat (2) @(negedge core_clk);
      chk(readValid, 1'b0);
      // Read of nonexistent port 12 gives no answer and keeps the last data
      access(ACC_READ, 4'hC, 8'h00, 1'b0);
      chk(readValid, 1'b0);
      chk(readData, 8'h3C);
      // Released port 1 with no source shows the low pull
      read_port(4'h1, 8'h00);
      suspend = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(pinDrive.oeN, '1);
      chk({pullEnable, accessReady}, 2'h0);
      suspend = 1'b0;
      repeat (8) @(negedge core_clk);
      chk(pinDrive.oeN, {{94{1'b1}}, 2'h0});
      tally_and_finish();
   end
endmodule : tb_static_dio_port
